// [core/pfcfg_register.v]
// profiling feature configuration register with gating and field outputs
// holds the 64-bit configuration word, its access path and its decode
// assumes msr requests are single-cycle strobes in the core clock domain
// assumes the feature, mask and capability inputs are steady levels
`timescale 1ns/1ps
`include "pfcfg_defs.vh"

module pfcfg_register #(
  parameter WIDTH = 64
) (
  // clock and reset
  input  wire             i_clock,
  input  wire             i_rst_n,
  // feature and state enables
  input  wire [31:0]      i_query_ext_features,
  input  wire [63:0]      i_xstate_enable_mask,
  input  wire [WIDTH-1:0] i_supported_mask,
  input  wire             i_cb_addr_nonzero,
  input  wire             i_timestamp_avail,
  // msr access
  input  wire             i_msr_rd,
  input  wire             i_msr_wr,
  input  wire [31:0]      i_msr_addr,
  input  wire [WIDTH-1:0] i_msr_wdata,
  output reg  [WIDTH-1:0] o_msr_rdata,
  output reg              o_msr_ack,
  output reg              o_gp_fault,
  // decoded configuration
  output wire [31:0]      o_query_leaf_eax,
  output wire             o_profiling_active,
  output wire             o_value_insert_enable,
  output wire [4:0]       o_event_enable,
  output wire             o_continuous_sampling_enable,
  output wire             o_timestamp_store_enable,
  output wire             o_threshold_int_enable,
  output wire [7:0]       o_core_tag,
  output wire [7:0]       o_int_vector
);

  // ----------------------------------------------------------------
  // access kinds and field positions
  // ----------------------------------------------------------------
  localparam [1:0] ACC_IDLE  = 2'b00;
  localparam [1:0] ACC_WRITE = 2'b01;
  localparam [1:0] ACC_READ  = 2'b10;
  localparam       NUM_EVT   = `PFCFG_EVT_HI - `PFCFG_EVT_LO + 1;

  localparam       VAL_POS   = `PFCFG_VAL_BIT;
  localparam       EVT_LO    = `PFCFG_EVT_LO;
  localparam       CONTINUOUS_SAMPLING_ENABLE_POS  = `PFCFG_CONTINUOUS_SAMPLING_ENABLE_BIT;
  localparam       TS_POS    = `PFCFG_TS_BIT;
  localparam       INT_POS   = `PFCFG_INT_BIT;
  localparam       TAG_LO    = `PFCFG_TAG_LO;
  localparam       VEC_LO    = `PFCFG_VEC_LO;
  localparam       MIR_LO    = `PFCFG_MIRROR_LO;
  localparam       MIR_HI    = `PFCFG_MIRROR_HI;

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  // address match, shared by the read and the write path
  function addr_match;
    input [31:0] addr;
    input        visible;
    begin
      addr_match = visible && (addr == `PFCFG_ADDR);
    end
  endfunction

  // write wins when both strobes arrive together
  function [1:0] acc_kind;
    input rd;
    input wr;
    begin
      if (wr) begin
        acc_kind = ACC_WRITE;
      end else if (rd) begin
        acc_kind = ACC_READ;
      end else begin
        acc_kind = ACC_IDLE;
      end
    end
  endfunction

  // reserved positions never hold a one, on store or on read
  function [WIDTH-1:0] impl_filter;
    input [WIDTH-1:0] value;
    begin
      impl_filter = value & `PFCFG_IMPL_MASK;
    end
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [WIDTH-1:0] profiling_feature_config;
  reg  [WIDTH-1:0] next_config;
  reg  [WIDTH-1:0] next_rdata;
  reg              next_ack;
  reg              next_fault;
  wire             msr_visible;
  wire             xstate_on;
  wire             hit;
  wire             legal;
  wire [1:0]       kind;

  // ----------------------------------------------------------------
  // gating
  // ----------------------------------------------------------------
  assign msr_visible = i_query_ext_features[`PFCFG_QUERY_BIT]; // [R1]
  assign xstate_on   = i_xstate_enable_mask[`PFCFG_XSTATE_BIT]; // [R2]
  // address zero keeps profiling off even after mask bit is set
  assign o_profiling_active = xstate_on & i_cb_addr_nonzero; // [R3]
  assign hit  = addr_match(i_msr_addr, msr_visible); // [R4]
  assign kind = acc_kind(i_msr_rd, i_msr_wr);

  pfcfg_write_check #(
    .WIDTH (WIDTH)
  ) u_check (
    .i_wdata     (i_msr_wdata),
    .i_supported (i_supported_mask),
    .o_legal     (legal)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // an unmapped or hidden address faults instead of acking silently
  always @* begin
    next_config = profiling_feature_config;
    next_rdata  = {WIDTH{1'b0}};
    next_ack    = 1'b0;
    next_fault  = 1'b0;
    case (kind)
      ACC_WRITE: begin
        if (hit && legal) begin
          next_config = impl_filter(i_msr_wdata);
          next_ack    = 1'b1;
        end else begin
          next_fault  = 1'b1; // [R5]
        end
      end
      ACC_READ: begin
        if (hit) begin
          next_rdata = impl_filter(profiling_feature_config); // [R17]
          next_ack   = 1'b1;
        end else begin
          next_fault = 1'b1; // [R1]
        end
      end
      default: begin
        next_ack = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register and access
  // ----------------------------------------------------------------
  // answers last one cycle; rdata is zero outside an ack
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      profiling_feature_config <= `PFCFG_RESET; // [R10]
      o_msr_rdata              <= {WIDTH{1'b0}};
      o_msr_ack                <= 1'b0;
      o_gp_fault               <= 1'b0;
    end else begin
      profiling_feature_config <= next_config;
      o_msr_rdata              <= next_rdata;
      o_msr_ack                <= next_ack;
      o_gp_fault               <= next_fault;
    end
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  genvar g;

  // bit 0 of the leaf is not part of the mirror
  assign o_query_leaf_eax[0] = 1'b0;
  generate
    for (g = MIR_LO; g <= MIR_HI; g = g + 1) begin : g_leaf
      assign o_query_leaf_eax[g] =
        profiling_feature_config[g]; // [R6]
    end
  endgenerate

  generate
    for (g = 0; g < NUM_EVT; g = g + 1) begin : g_evt
      assign o_event_enable[g] =
        profiling_feature_config[EVT_LO + g]; // [R12]
    end
  endgenerate

  assign o_value_insert_enable =
    profiling_feature_config[VAL_POS]; // [R11]

  assign o_continuous_sampling_enable =
    profiling_feature_config[CONTINUOUS_SAMPLING_ENABLE_POS]; // [R13]

  assign o_timestamp_store_enable =
    profiling_feature_config[TS_POS] & i_timestamp_avail; // [R14]

  assign o_threshold_int_enable =
    profiling_feature_config[INT_POS]; // [R15]

  assign o_core_tag =
    profiling_feature_config[TAG_LO +: 8]; // [R7]

  // vector validity is software's duty when the interrupt is enabled
  assign o_int_vector =
    profiling_feature_config[VEC_LO +: 8]; // [R9]

endmodule // pfcfg_register

// [include/pfcfg_defs.vh]
// constants for the profiling feature configuration register block
// assumes one core clock domain and a model-specific register access port
//
// Contract
// [R1] registers accessible only when feature-query bit 15 reports profiling
// [R2] profiling usable only once extended-state enable mask bit 62 is set
// [R3] setting mask bit 62 leaves profiling off; control block address zero
// [R4] configuration register decoded at address C000_0105h
// [R5] write setting any unsupported bit faults and leaves register unchanged
// [R6] configuration bits 31:1 mirrored into the feature-query result leaf
// [R7] core tag bits 39:32 copied into every event record's core field
// [R8] software should load core tag from local interrupt controller number
// [R9] bits 47:40 give the threshold interrupt vector number
// [R10] reset clears the whole configuration register to zero
// [R11] bit 1 permits the user value-insertion instruction
// [R12] bits 2 to 6 each enable counting of one event type
// [R13] bit 29 enables continuous sampling, otherwise synchronized mode
// [R14] bit 30 stores timestamp counter in records when counter available
// [R15] bit 31 permits the ring buffer threshold interrupt
// [R16] software enabling threshold interrupt also programs a valid vector
// [R17] reads return the stored value; reserved positions read zero
`ifndef PFCFG_DEFS_VH
`define PFCFG_DEFS_VH

// ----------------------------------------------------------------
// addresses and bit positions
// ----------------------------------------------------------------
`define PFCFG_ADDR        32'hC0000105
`define PFCFG_RESET       64'h0000000000000000
`define PFCFG_QUERY_BIT   15
`define PFCFG_XSTATE_BIT  62
`define PFCFG_VAL_BIT     1
`define PFCFG_EVT_LO      2
`define PFCFG_EVT_HI      6
`define PFCFG_CONTINUOUS_SAMPLING_ENABLE_BIT    29
`define PFCFG_TS_BIT      30
`define PFCFG_INT_BIT     31
`define PFCFG_TAG_HI      39
`define PFCFG_TAG_LO      32
`define PFCFG_VEC_HI      47
`define PFCFG_VEC_LO      40
`define PFCFG_MIRROR_HI   31
`define PFCFG_MIRROR_LO   1
// implemented positions: 47:29 and 6:1
`define PFCFG_IMPL_MASK   64'h0000FFFFE000007E

`endif

// [core/pfcfg_write_check.v]
// write legality check against the supported-feature mask
// assumes the capability mask is steady while a write is presented
`timescale 1ns/1ps
`include "pfcfg_defs.vh"

module pfcfg_write_check #(
  parameter WIDTH = 64
) (
  // write data and capability
  input  wire [WIDTH-1:0] i_wdata,
  input  wire [WIDTH-1:0] i_supported,
  // verdict
  output wire             o_legal
);

  // ----------------------------------------------------------------
  // check
  // ----------------------------------------------------------------
  // tag and vector carry no capability bit, so they are always allowed
  wire [WIDTH-1:0] allowed;
  assign allowed = i_supported |
                   {{(WIDTH-48){1'b0}}, 16'hFFFF, 32'h00000000};
  assign o_legal = ~|(i_wdata & ~allowed); // [R5]

endmodule // pfcfg_write_check

// [tb/pfcfg_asserts.sv]
// checker on the profiling config register ports
// assumes a bind onto pfcfg_register
`timescale 1ns/1ps
`include "pfcfg_defs.vh"
module pfcfg_asserts (
  input wire i_clock, i_rst_n, i_msr_rd, i_msr_wr, i_cb_addr_nonzero,
  input wire i_timestamp_avail, o_msr_ack, o_gp_fault, o_profiling_active,
  input wire o_value_insert_enable, o_timestamp_store_enable,
  input wire [31:0] i_query_ext_features, i_msr_addr, o_query_leaf_eax,
  input wire [63:0] i_xstate_enable_mask, i_supported_mask, i_msr_wdata,
  input wire [63:0] o_msr_rdata,
  input wire [7:0] o_core_tag, o_int_vector,
  input wire [4:0] o_event_enable);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire ok = i_msr_addr == `PFCFG_ADDR && i_query_ext_features[15];
  wire bad = |(i_msr_wdata & ~(i_supported_mask | 64'h0000FFFF00000000));
  a_rd_ack: assert property (i_msr_rd && !i_msr_wr && ok |=> o_msr_ack)
    else $error("read not acked");
  a_bad_gp: assert property ((i_msr_rd|i_msr_wr) && !ok |=> o_gp_fault)
    else $error("no fault");
  a_wr_refused: assert property (i_msr_wr && bad |=> o_gp_fault &&
    $stable({o_int_vector, o_core_tag})) else $error("bad write taken");
  a_wr_fields: assert property (i_msr_wr && ok && !bad |=>
    {o_int_vector, o_core_tag} == $past(i_msr_wdata[47:32]))
    else $error("fields not written");
  a_leaf_low: assert property (o_query_leaf_eax[6:0] ==
    {o_event_enable, o_value_insert_enable, 1'b0}) else $error("leaf");
  a_act_gate: assert property (o_profiling_active ==
    (i_xstate_enable_mask[62] && i_cb_addr_nonzero)) else $error("active");
  a_rd_clean: assert property (!o_msr_ack |-> o_msr_rdata == 64'h0)
    else $error("stray rdata");
  a_ts_gate: assert property (o_timestamp_store_enable |->
    i_timestamp_avail && o_query_leaf_eax[30]) else $error("stamp");
endmodule // pfcfg_asserts
bind pfcfg_register pfcfg_asserts u_asserts (.*);

// [tb/pfcfg_register_bench.sv]
// bench: msr reads and writes on the profiling config register
// assumes a 50 ns clock; the checker is bound separately
`timescale 1ns/1ps
`include "pfcfg_defs.vh"
module profiling_config_register_bench;
  logic i_clock = 0, i_rst_n = 0, i_msr_rd = 0, i_msr_wr = 0;
  logic i_cb_addr_nonzero = 0, i_timestamp_avail = 1;
  logic [31:0] i_query_ext_features = 32'h8000, i_msr_addr = '0;
  logic [63:0] i_xstate_enable_mask = '0, i_supported_mask = '0;
  logic [63:0] i_msr_wdata = '0, o_msr_rdata;
  logic [31:0] o_query_leaf_eax;
  logic [7:0] o_core_tag, o_int_vector;
  logic [4:0] o_event_enable;
  logic o_msr_ack, o_gp_fault, o_profiling_active, o_value_insert_enable;
  logic o_continuous_sampling_enable, o_timestamp_store_enable;
  logic o_threshold_int_enable;
  int n_mismatch = 0, check_count = 0, cycles = 0;
  localparam V = 64'h0000A5C3E000007E;
  pfcfg_register u_dut (.*);
  initial forever #25 i_clock = ~i_clock;
  // generous ceiling; the tests need about 50 cycles
  always @(posedge i_clock) if (++cycles == 2000) begin
    n_mismatch++;
    close_out;
  end
  task automatic chk(string s, logic [63:0] e, logic [63:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // one-cycle strobe, answer sampled one edge later
  task automatic acc(bit w, logic [31:0] a, logic [63:0] d, bit f);
    @(posedge i_clock) #1;
    {i_msr_wr, i_msr_rd, i_msr_addr, i_msr_wdata} = {w, !w, a, d};
    @(posedge i_clock) #1;
    {i_msr_wr, i_msr_rd} = 2'h0;
    chk("fault", f, o_gp_fault);
    chk("ack", !f, o_msr_ack);
  endtask
  task automatic rd(logic [63:0] e);
    acc(0, `PFCFG_ADDR, '0, 0);
    chk("rdata", e, o_msr_rdata);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clock);
    #1 i_rst_n = 1;
    rd('0);
    i_supported_mask = 64'h00000000E000007F;
    acc(1, `PFCFG_ADDR, 64'h1, 0);
    rd('0);
    for (int i = 0; i < 6; i++) begin
      acc(1, `PFCFG_ADDR, 64'h2 << i, 0);
      chk("events", 6'h1 << i, {o_event_enable, o_value_insert_enable});
    end
    acc(1, `PFCFG_ADDR, V, 0);
    rd(V);
    chk("tag", 16'hA5C3, {o_int_vector, o_core_tag});
    chk("leaf", 32'hE000007E, o_query_leaf_eax);
    chk("modes", 3'h7, {o_threshold_int_enable, o_continuous_sampling_enable,
      o_timestamp_store_enable});
    i_timestamp_avail = 0;
    #1 chk("stamp", 0, o_timestamp_store_enable);
    $display("test fields done");
    acc(1, `PFCFG_ADDR, 64'h100, 1);
    rd(V);
    acc(0, 32'hC0000106, '0, 1);
    i_query_ext_features = '0;
    acc(0, `PFCFG_ADDR, '0, 1);
    i_xstate_enable_mask = 64'h4000000000000000;
    #1 chk("active", 0, o_profiling_active);
    @(posedge i_clock) #1 i_cb_addr_nonzero = 1;
    #1 chk("active", 1, o_profiling_active);
    @(posedge i_clock) #1 i_rst_n = 0;
    #1 chk("reset", 0, {o_int_vector, o_core_tag});
    @(posedge i_clock) #1 i_rst_n = 1;
    i_query_ext_features = 32'h8000;
    rd('0);
    $display("test faults done");
    close_out;
  end
endmodule // profiling_config_register_bench
